// >>> hw/gic_idle_gate.sv
// Purpose: idle detection and clock gate requests for the graphics core
// Assumes: activity and instruction inputs come from logic on clk_in
// Notes:   gate outputs high mean the clock may be stopped
// What this block does
// - watch activity, tell 3D idle from full idle
// - raise gate requests once idle and expired
// - decode instruction, request only needed clocks
// - wait settling interval after enabling clocks from gated or while counting
// - load timeout then decrement every cycle
// - reload timeout on any further activity
// - expiry with no need regates, resumes watching
`timescale 1ns/1ps
module gic_idle_gate
	import gic_pkg::*;
(
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	input  wire logic [TIMEOUT_WIDTH-1:0] timeout_in,
	input  wire logic                     bus_active_in,
	input  wire logic                     core_2d_active_in,
	input  wire logic                     core_3d_active_in,
	input  wire logic                     instr_valid_in,
	input  wire logic                     instr_needs_2d_in,
	input  wire logic                     instr_needs_3d_in,
	output logic                          bus_interface_clock_gate_out,
	output logic                          core_2d_clock_gate_out,
	output logic                          core_3d_clock_gate_out,
	output logic                          idle_3d_out,
	output logic                          idle_all_out,
	output gic_mode_type                  mode_out
);
	import gic_pkg::*;

	gic_state_type            state;
	gic_state_type            next_state;
	gic_mode_type             mode;
	gic_mode_type             next_mode;
	logic [SETTLE_WIDTH-1:0]  settle;
	logic [SETTLE_WIDTH-1:0]  next_settle;
	logic                     gate_bus;
	logic                     gate_2d;
	logic                     gate_3d;
	logic                     next_gate_bus;
	logic                     next_gate_2d;
	logic                     next_gate_3d;
	logic                     idle_3d;
	logic                     idle_all;
	logic                     any_active;
	logic                     cnt_load;
	logic                     cnt_dec;
	logic                     cnt_zero;
	logic [TIMEOUT_WIDTH-1:0] cnt_value;
	gic_mode_type             want_mode;

	// idle classification from internal activity
	assign idle_3d    = !core_3d_active_in;
	assign idle_all   = !core_3d_active_in && !core_2d_active_in;
	assign any_active = bus_active_in || core_2d_active_in ||
		core_3d_active_in || instr_valid_in;

	// decode: the mode the pending instruction needs
	always_comb begin
		want_mode = GIC_MODE_BUS;
		if (instr_needs_3d_in) begin
			want_mode = GIC_MODE_3D;
		end else if (instr_needs_2d_in) begin
			want_mode = GIC_MODE_2D;
		end
	end

	// sequencer: gated, settle, count down
	always_comb begin
		next_state  = state;
		next_mode   = mode;
		next_settle = settle;
		cnt_load    = 1'b0;
		cnt_dec     = 1'b0;
		unique case (state)
			GIC_ST_GATED: begin
				if (instr_valid_in) begin
					next_mode   = want_mode;
					next_settle = SETTLE_LOAD;
					next_state  = GIC_ST_SETTLE;
				end
			end
			GIC_ST_SETTLE: begin
				// no countdown until clocks are stable
				if (instr_valid_in && want_mode > mode) begin
					next_mode = want_mode;
				end
				if (settle == SETTLE_ZERO) begin
					cnt_load   = 1'b1;
					next_state = GIC_ST_COUNT;
				end else begin
					next_settle = settle - 4'h1;
				end
			end
			GIC_ST_COUNT: begin
				if (instr_valid_in && want_mode > mode) begin
					// a wider need reopens clocks and settles again
					next_mode   = want_mode;
					next_settle = SETTLE_LOAD;
					next_state  = GIC_ST_SETTLE;
				end else if (any_active) begin
					cnt_load = 1'b1;
				end else if (cnt_zero) begin
					next_mode  = GIC_MODE_DEEP;
					next_state = GIC_ST_GATED;
				end else begin
					cnt_dec = 1'b1;
				end
			end
		endcase
	end

	// gate requests follow the mode; registered so the clock handler
	// never sees a decode glitch as a request to stop a clock
	always_comb begin
		next_gate_bus = (next_mode == GIC_MODE_DEEP);
		next_gate_2d  = (next_mode == GIC_MODE_DEEP) ||
			(next_mode == GIC_MODE_BUS);
		next_gate_3d  = (next_mode != GIC_MODE_3D);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state    <= GIC_ST_GATED;
			mode     <= GIC_MODE_DEEP;
			settle   <= SETTLE_ZERO;
			gate_bus <= 1'b1;
			gate_2d  <= 1'b1;
			gate_3d  <= 1'b1;
		end else begin
			state    <= next_state;
			mode     <= next_mode;
			settle   <= next_settle;
			gate_bus <= next_gate_bus;
			gate_2d  <= next_gate_2d;
			gate_3d  <= next_gate_3d;
		end
	end

	// idle timer, reloaded from the programmed timeout
	gic_down_counter u_idle_timer (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.load_in       (cnt_load),
		.load_value_in (timeout_in),
		.dec_in        (cnt_dec),
		.count_out     (cnt_value),
		.zero_out      (cnt_zero)
	);

	assign bus_interface_clock_gate_out = gate_bus;
	assign core_2d_clock_gate_out       = gate_2d;
	assign core_3d_clock_gate_out       = gate_3d;
	assign idle_3d_out                  = idle_3d;
	assign idle_all_out                 = idle_all;
	assign mode_out                     = mode;

	sequence s_settle_run;
		(state == GIC_ST_SETTLE) [*8];
	endsequence

	sequence s_loaded;
		(state == GIC_ST_COUNT) && (cnt_value == $past(timeout_in));
	endsequence

	chk_settle_then_load: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_GATED && instr_valid_in) |=>
		s_settle_run ##1 s_loaded)
		else $error("settle length or timer load wrong");

	chk_reload_on_act: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_COUNT && any_active && !instr_valid_in) |=>
		cnt_value == $past(timeout_in))
		else $error("timer not reloaded on activity");

	chk_decrement_one: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_COUNT && !any_active && !cnt_zero) |=>
		cnt_value == $past(cnt_value) - COUNT_ONE)
		else $error("timer did not step down by one");

	chk_expiry_gates: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_COUNT && !any_active && cnt_zero) |=>
		state == GIC_ST_GATED && gate_bus && gate_2d && gate_3d)
		else $error("expiry did not gate all clocks");

	chk_gates_need_idle: assert property (@(posedge clk_in)
		disable iff (rst_in)
		$rose(gate_bus) |-> $past(cnt_zero) && $past(!any_active))
		else $error("gate raised without idle expiry");

	chk_decode_3d: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_GATED && instr_valid_in && instr_needs_3d_in)
		|=> !gate_3d && !gate_2d && !gate_bus)
		else $error("3D instruction did not open all clocks");

	chk_decode_bus: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_GATED && instr_valid_in && !instr_needs_3d_in
		&& !instr_needs_2d_in) |=> !gate_bus && gate_2d && gate_3d)
		else $error("bus-only instruction opened extra clocks");

	chk_decode_2d: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(state == GIC_ST_GATED && instr_valid_in && !instr_needs_3d_in
		&& instr_needs_2d_in) |=> !gate_bus && !gate_2d && gate_3d)
		else $error("2D instruction opened wrong clocks");

	chk_mode_gates: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(mode == GIC_MODE_2D) |-> !gate_bus && !gate_2d && gate_3d)
		else $error("2D mode gate pattern wrong");

	chk_idle_split: assert property (@(posedge clk_in)
		disable iff (rst_in)
		(idle_3d_out == !core_3d_active_in) &&
		(idle_all_out == (idle_3d_out && !core_2d_active_in)))
		else $error("idle flags disagree with activity");
endmodule

// >>> hw/gic_pkg.sv
// Purpose: shared constants and types for the graphics idle clock gating
// Assumes: single clock domain, synchronous active-high reset
// Notes:   timeout width covers the largest programmable timeout
package gic_pkg;
	localparam int unsigned TIMEOUT_WIDTH = 16;
	localparam int unsigned SETTLE_CYCLES = 8;
	localparam int unsigned SETTLE_WIDTH  = 4;
	localparam logic [SETTLE_WIDTH-1:0] SETTLE_LOAD =
		SETTLE_WIDTH'(SETTLE_CYCLES - 1);
	localparam logic [SETTLE_WIDTH-1:0] SETTLE_ZERO = 4'h0;
	localparam logic [TIMEOUT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [TIMEOUT_WIDTH-1:0] COUNT_ONE  = 16'h0001;

	// operation modes, one-hot
	typedef enum logic [3:0] {
		GIC_MODE_DEEP = 4'h1,
		GIC_MODE_BUS  = 4'h2,
		GIC_MODE_2D   = 4'h4,
		GIC_MODE_3D   = 4'h8
	} gic_mode_type;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		GIC_ST_GATED  = 3'h1,
		GIC_ST_SETTLE = 3'h2,
		GIC_ST_COUNT  = 3'h4
	} gic_state_type;
endpackage

// >>> hw/gic_down_counter.sv
// Purpose: loadable down counter used as the idle timer
// Assumes: clk_in clock, rst_in synchronous active high
// Notes:   load has priority over decrement; holds at zero
`timescale 1ns/1ps
module gic_down_counter
	import gic_pkg::*;
(
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	input  wire logic                     load_in,
	input  wire logic [TIMEOUT_WIDTH-1:0] load_value_in,
	input  wire logic                     dec_in,
	output logic      [TIMEOUT_WIDTH-1:0] count_out,
	output logic                          zero_out
);
	logic [TIMEOUT_WIDTH-1:0] count;
	logic [TIMEOUT_WIDTH-1:0] next_count;

	// load wins so fresh activity always restarts the full timeout
	always_comb begin
		next_count = count;
		if (load_in) begin
			next_count = load_value_in;
		end else if (dec_in && count != COUNT_ZERO) begin
			next_count = count - COUNT_ONE;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	assign count_out = count;
	assign zero_out  = (count == COUNT_ZERO);
endmodule

// >>> tb/gic_clock_handler.sv
// Purpose: model of the chip clock handler fed by the gate requests
// Assumes: a gate request high means that clock may stop
// Notes:   no gating cell modelled, so it answers at once
`timescale 1ns/1ps
module gic_clock_handler
(
	input  wire logic            bus_gate_in,
	input  wire logic            core_2d_gate_in,
	input  wire logic            core_3d_gate_in,
	output gic_pkg::gic_mode_type mode_out
);
	import gic_pkg::*;
	logic [2:0] run;
	// a clock runs only while its gate request is low
	assign run = ~{bus_gate_in, core_2d_gate_in, core_3d_gate_in};
	// odd run patterns read as deep so the bench sees them wrong
	always_comb begin
		case (run)
			3'h4:    mode_out = GIC_MODE_BUS;
			3'h6:    mode_out = GIC_MODE_2D;
			3'h7:    mode_out = GIC_MODE_3D;
			default: mode_out = GIC_MODE_DEEP;
		endcase
	end
endmodule

// >>> tb/gic_idle_gate_test.sv
// Purpose: self-checking bench for the idle clock gating block
// Assumes: inputs change at the falling edge, settle of SETTLE_CYCLES
// Notes:   gate order in checks is bus, 2D, 3D
`timescale 1ns/1ps
module gic_idle_gate_test;
	import gic_pkg::*;
	typedef struct packed {
		logic         n2;
		logic         n3;
		logic [15:0]  tmo;
		logic [2:0]   gates;
		gic_mode_type mode;
	} gic_row_type;
	logic         clk_in;
	logic         rst_in;
	logic         act_bus;
	logic         act_2d;
	logic         act_3d;
	logic         iv;
	logic         n2;
	logic         n3;
	logic [15:0]  tmo;
	logic         gb;
	logic         g2;
	logic         g3;
	logic         idle_3d;
	logic         idle_all;
	gic_mode_type mode;
	gic_mode_type seen_mode;
	int           mismatches;
	int           check_count;
	int           cyc;
	// instruction kind, timeout, expected gates and mode
	gic_row_type  rows [4] = '{
		'{1'b0, 1'b0, 16'h0003, 3'h3, GIC_MODE_BUS},
		'{1'b1, 1'b0, 16'h0005, 3'h1, GIC_MODE_2D},
		'{1'b0, 1'b1, 16'h0000, 3'h0, GIC_MODE_3D},
		'{1'b1, 1'b1, 16'h0001, 3'h0, GIC_MODE_3D}};
	gic_idle_gate dut (.clk_in(clk_in), .rst_in(rst_in), .timeout_in(tmo),
		.bus_active_in(act_bus), .core_2d_active_in(act_2d),
		.core_3d_active_in(act_3d), .instr_valid_in(iv),
		.instr_needs_2d_in(n2), .instr_needs_3d_in(n3),
		.bus_interface_clock_gate_out(gb), .core_2d_clock_gate_out(g2),
		.core_3d_clock_gate_out(g3), .idle_3d_out(idle_3d),
		.idle_all_out(idle_all), .mode_out(mode));
	gic_clock_handler partner (.bus_gate_in(gb), .core_2d_gate_in(g2),
		.core_3d_gate_in(g3), .mode_out(seen_mode));
	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic go(int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic see(logic [2:0] g, gic_mode_type m);
		chk("gates", {5'h00, gb, g2, g3}, {5'h00, g});
		chk("mode", {4'h0, mode}, {4'h0, m});
		chk("handler", {4'h0, seen_mode}, {4'h0, m});
	endtask
	// one instruction taken at the next rising edge
	task automatic instr(logic a, logic b);
		iv = 1'b1;
		n2 = a;
		n3 = b;
		go(1);
		iv = 1'b0;
	endtask
	// a hang is cut short well past the longest run
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		{rst_in, act_bus, act_2d, act_3d, iv, n2, n3} = 7'h40;
		tmo = 16'h0000;
		go(5);
		see(3'h7, GIC_MODE_DEEP);
		rst_in = 1'b0;
		foreach (rows[i]) begin
			tmo = rows[i].tmo;
			instr(rows[i].n2, rows[i].n3);
			go(1);
			see(rows[i].gates, rows[i].mode);
			// last cycle before expiry: settle left plus full count
			go(SETTLE_CYCLES - 1 + int'(rows[i].tmo));
			see(rows[i].gates, rows[i].mode);
			go(1);
			see(3'h7, GIC_MODE_DEEP);
		end
		// one busy cycle near the end must push expiry out
		tmo = 16'h0004;
		instr(1'b0, 1'b0);
		go(11);
		act_bus = 1'b1;
		go(1);
		act_bus = 1'b0;
		go(4);
		see(3'h3, GIC_MODE_BUS);
		go(1);
		see(3'h7, GIC_MODE_DEEP);
		// wider need while counting widens and settles again
		tmo = 16'h0014;
		instr(1'b0, 1'b0);
		go(10);
		instr(1'b0, 1'b1);
		go(1);
		see(3'h0, GIC_MODE_3D);
		go(SETTLE_CYCLES + 19);
		see(3'h0, GIC_MODE_3D);
		go(1);
		see(3'h7, GIC_MODE_DEEP);
		// reset in mid-run drops every clock; restart at first edge
		instr(1'b0, 1'b1);
		go(3);
		rst_in = 1'b1;
		go(3);
		see(3'h7, GIC_MODE_DEEP);
		rst_in = 1'b0;
		tmo = 16'h0000;
		instr(1'b1, 1'b0);
		go(1);
		see(3'h1, GIC_MODE_2D);
		go(SETTLE_CYCLES - 1);
		see(3'h1, GIC_MODE_2D);
		go(1);
		see(3'h7, GIC_MODE_DEEP);
		// idle flags follow activity directly
		act_3d = 1'b1;
		go(1);
		chk("idle", {6'h00, idle_3d, idle_all}, 8'h00);
		act_3d = 1'b0;
		act_2d = 1'b1;
		go(1);
		chk("idle", {6'h00, idle_3d, idle_all}, 8'h02);
		act_2d = 1'b0;
		act_bus = 1'b1;
		go(1);
		chk("idle", {6'h00, idle_3d, idle_all}, 8'h03);
		see(3'h7, GIC_MODE_DEEP);
		wrap_up();
	end
endmodule
